// >>> hdl/vsu_pkg.sv
// Purpose: Shared constants and carrier types for the vector subtract unit
// Assumes: 32-bit general registers, 32-bit extension control register
// Notes: Opcode field positions follow the extension instruction format
package vsu_pkg;

  localparam int VSU_WORD_W = 32;
  localparam logic [5:0] VSU_MAJOR_OP = 6'h1F;
  localparam logic [5:0] VSU_FN_HALVING = 6'h18;
  localparam logic [5:0] VSU_FN_VECTOR = 6'h10;
  localparam logic [4:0] VSU_SUB_HWS = 5'h11;
  localparam logic [4:0] VSU_SUB_HWS_R = 5'h13;
  localparam logic [4:0] VSU_SUB_PAIR = 5'h09;
  localparam logic [4:0] VSU_SUB_PAIR_S = 5'h0D;
  localparam logic [4:0] VSU_SUB_QUAD = 5'h01;
  localparam logic [4:0] VSU_SUB_QUAD_S = 5'h05;
  localparam int VSU_MAJ_POS = 26;
  localparam int VSU_SRC1_POS = 21;
  localparam int VSU_SRC2_POS = 16;
  localparam int VSU_DST_POS = 11;
  localparam int VSU_SUBOP_POS = 6;
  localparam int VSU_OUFLAG_BIT = 20;
  localparam logic [31:0] VSU_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] VSU_RESULT_RESET = 32'h0000_0000;

  typedef enum {
    VSU_OP_NONE,
    VSU_OP_HWS,
    VSU_OP_HWS_R,
    VSU_OP_PAIR,
    VSU_OP_PAIR_S,
    VSU_OP_QUAD,
    VSU_OP_QUAD_S
  } vsu_op_type;

  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [31:0] src1;
    logic [31:0] src2;
  } vsu_req_type;

  typedef struct packed {
    logic valid;
    logic [4:0] dst;
    logic [31:0] data;
  } vsu_rsp_type;

endpackage

// >>> hdl/vsu_unit.sv
// Purpose: Halving word, unsigned pair and unsigned quad-byte subtract datapath
// Assumes: Pipeline presents decoded operands with a valid flag, one per cycle
// Notes: One cycle latency; unknown encodings give a reserved-instruction pulse
//
// Operation
// - Halving word subtract: sign-extend both words, first minus second, 33 bits.
// - Non-rounding halving form writes bits 32..1 of the difference.
// - Rounding halving form adds one before the one-bit shift.
// - Halving forms leave the extension control register untouched.
// - Pair subtract: zero-extend halves, second-source minus first-source element.
// - Non-saturating pair writes low 16 bits of each difference in place.
// - Saturating pair clamps underflowed halves to zero.
// - Either pair form sets control bit 20 on any halfword underflow.
// - Quad subtract: each first-source byte minus second-source byte, lanes kept.
// - Non-saturating quad writes each lane difference modulo 256.
// - Saturating quad clamps underflowed bytes to zero.
// - Either quad form sets control bit 20 on any byte underflow.
// - Only reserved-instruction and extension-disabled traps are raised.
// - Operand values never raise a trap; wrap, clamp or flag only.
`timescale 1ns/100ps
module vsu_unit
  import vsu_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Pipeline request
  input vsu_req_type req,
  input wire logic ext_enable,
  // Control register as held by the pipeline
  input wire logic [31:0] ctrl_in,
  // Answer
  output vsu_rsp_type rsp_ff,
  output logic [31:0] ctrl_ff,
  output logic ctrl_we_ff,
  output logic trap_reserved_ff,
  output logic trap_disabled_ff
);

  vsu_op_type op;
  logic is_ext;
  logic [32:0] word_diff;
  logic [32:0] word_round;
  logic [1:0] pair_under;
  logic [31:0] pair_wrap;
  logic [31:0] pair_sat;
  logic [3:0] quad_under;
  logic [31:0] quad_wrap;
  logic [31:0] quad_sat;
  logic [31:0] nxt_data;
  logic nxt_flag;

  always_comb begin
    is_ext = req.instr[31:VSU_MAJ_POS] == VSU_MAJOR_OP;
    op = VSU_OP_NONE;
    if (is_ext && req.instr[5:0] == VSU_FN_HALVING) begin
      case (req.instr[10:VSU_SUBOP_POS])
        VSU_SUB_HWS: op = VSU_OP_HWS;
        VSU_SUB_HWS_R: op = VSU_OP_HWS_R;
        default: op = VSU_OP_NONE;
      endcase
    end else if (is_ext && req.instr[5:0] == VSU_FN_VECTOR) begin
      case (req.instr[10:VSU_SUBOP_POS])
        VSU_SUB_PAIR: op = VSU_OP_PAIR;
        VSU_SUB_PAIR_S: op = VSU_OP_PAIR_S;
        VSU_SUB_QUAD: op = VSU_OP_QUAD;
        VSU_SUB_QUAD_S: op = VSU_OP_QUAD_S;
        default: op = VSU_OP_NONE;
      endcase
    end
  end

  assign word_diff = {req.src1[31], req.src1} - {req.src2[31], req.src2};
  assign word_round = word_diff + 33'h0_0000_0001;

  // Lane arithmetic: 17- and 9-bit unsigned differences, borrow is underflow
  generate
    for (genvar h = 0; h < 2; h++) begin : g_pair
      logic [16:0] d;
      assign d = {1'b0, req.src2[16*h +: 16]} - {1'b0, req.src1[16*h +: 16]};
      assign pair_under[h] = d[16];
      assign pair_wrap[16*h +: 16] = d[15:0];
      assign pair_sat[16*h +: 16] = d[16] ? 16'h0000 : d[15:0];
    end
    for (genvar b = 0; b < 4; b++) begin : g_quad
      logic [8:0] d;
      // first source minus second, per lane
      assign d = {1'b0, req.src1[8*b +: 8]} - {1'b0, req.src2[8*b +: 8]};
      assign quad_under[b] = d[8];
      assign quad_wrap[8*b +: 8] = d[7:0];
      assign quad_sat[8*b +: 8] = d[8] ? 8'h00 : d[7:0];
    end
  endgenerate

  always_comb begin
    nxt_data = VSU_RESULT_RESET;
    nxt_flag = 1'b0;
    case (op)
      VSU_OP_HWS: nxt_data = word_diff[32:1];
      VSU_OP_HWS_R: nxt_data = word_round[32:1];
      VSU_OP_PAIR: begin
        nxt_data = pair_wrap;
        nxt_flag = |pair_under;
      end
      VSU_OP_PAIR_S: begin
        nxt_data = pair_sat;
        nxt_flag = |pair_under;
      end
      VSU_OP_QUAD: begin
        nxt_data = quad_wrap;
        nxt_flag = |quad_under;
      end
      VSU_OP_QUAD_S: begin
        nxt_data = quad_sat;
        nxt_flag = |quad_under;
      end
      default: nxt_data = VSU_RESULT_RESET;
    endcase
  end

  // Result write-back
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.valid <= req.valid && ext_enable && op != VSU_OP_NONE;
      rsp_ff.dst <= req.instr[15:VSU_DST_POS];
      rsp_ff.data <= nxt_data;
    end
  end

  // Control register update: only bit 20 may be set, never cleared here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= VSU_CTRL_RESET;
      ctrl_we_ff <= 1'b0;
    end else begin
      ctrl_we_ff <= req.valid && ext_enable && nxt_flag;
      ctrl_ff <= ctrl_in | ({31'h0, nxt_flag} << VSU_OUFLAG_BIT);
    end
  end

  // Traps: only encoding and enable matter, never operand values
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      trap_reserved_ff <= 1'b0;
      trap_disabled_ff <= 1'b0;
    end else begin
      trap_reserved_ff <= req.valid && is_ext && op == VSU_OP_NONE;
      trap_disabled_ff <= req.valid && !ext_enable && op != VSU_OP_NONE;
    end
  end

  // Halving reference values use 64-bit signed arithmetic, not the datapath's own nets
  chk_halving_no_ctrl: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && (op == VSU_OP_HWS || op == VSU_OP_HWS_R)) |=> !ctrl_we_ff)
    else $error("halving subtract wrote control register");
  chk_halving_value: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && ext_enable && op == VSU_OP_HWS)
      |=> rsp_ff.data == 32'((longint'($signed($past(req.src1)))
        - longint'($signed($past(req.src2)))) >>> 1))
    else $error("halving result wrong");
  chk_round_value: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && ext_enable && op == VSU_OP_HWS_R)
      |=> rsp_ff.data == 32'((longint'($signed($past(req.src1)))
        - longint'($signed($past(req.src2))) + 1) >>> 1))
    else $error("rounded halving result wrong");
  chk_pair_flag: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && ext_enable && (op == VSU_OP_PAIR || op == VSU_OP_PAIR_S)
      && (req.src2[15:0] < req.src1[15:0] || req.src2[31:16] < req.src1[31:16]))
      |=> ctrl_we_ff && ctrl_ff[VSU_OUFLAG_BIT])
    else $error("pair underflow flag missing");
  chk_pair_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && ext_enable && op == VSU_OP_PAIR)
      |=> rsp_ff.data[31:16] == 16'($past(req.src2[31:16]) - $past(req.src1[31:16])))
    else $error("pair wrap result wrong");
  chk_pair_sat: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && ext_enable && op == VSU_OP_PAIR_S && (req.src2[31:16] < req.src1[31:16]))
      |=> rsp_ff.data[31:16] == 16'h0000)
    else $error("pair saturation missing");
  chk_quad_sat: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && ext_enable && op == VSU_OP_QUAD_S && (req.src1[31:24] < req.src2[31:24]))
      |=> rsp_ff.data[31:24] == 8'h00 && ctrl_ff[VSU_OUFLAG_BIT])
    else $error("quad saturation missing");
  chk_quad_flag: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && ext_enable && (op == VSU_OP_QUAD || op == VSU_OP_QUAD_S)
      && (req.src1[31:24] < req.src2[31:24] || req.src1[7:0] < req.src2[7:0]))
      |=> ctrl_we_ff && ctrl_ff[VSU_OUFLAG_BIT])
    else $error("quad underflow flag missing");
  chk_quad_wrap: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && ext_enable && op == VSU_OP_QUAD)
      |=> rsp_ff.data[15:8] == 8'($past(req.src1[15:8]) - $past(req.src2[15:8])))
    else $error("quad wrap result wrong");
  chk_ctrl_keep: assert property (@(posedge clock) disable iff (!rst_n)
    req.valid |=> (ctrl_ff & ~32'h0010_0000) == ($past(ctrl_in) & ~32'h0010_0000))
    else $error("control bits other than flag changed");
  chk_trap_kinds: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && ext_enable && op != VSU_OP_NONE)
      |=> !trap_reserved_ff && !trap_disabled_ff)
    else $error("trap raised for valid operation");
  chk_disabled_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (req.valid && !ext_enable && op != VSU_OP_NONE)
      |=> trap_disabled_ff && !rsp_ff.valid && !ctrl_we_ff)
    else $error("disabled extension still answered");

  cov_pair_under: cover property (@(posedge clock) req.valid && op == VSU_OP_PAIR_S
    && |pair_under);
  cov_quad_under: cover property (@(posedge clock) req.valid && op == VSU_OP_QUAD
    && |quad_under);
  cov_round: cover property (@(posedge clock) req.valid && op == VSU_OP_HWS_R);
  cov_reserved: cover property (@(posedge clock) trap_reserved_ff);
  cov_disabled: cover property (@(posedge clock) trap_disabled_ff);

endmodule

// >>> verif/vsu_pipe_model.sv
// Purpose: Pipeline side model holding the extension control register
// Assumes: The unit asks for a write-back through a one-cycle pulse
// Notes: Nonzero reset value, so that untouched fields stay visible
`timescale 1ns/100ps
module vsu_pipe_model #(
  parameter logic [31:0] CTRL_INIT = 32'h0A00_2C15
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Write-back from the unit
  input wire logic ctrl_we,
  input wire logic [31:0] ctrl_new,
  // Held value
  output logic [31:0] ctrl_ff
);
  // Taken whole: the unit has already merged the flag into the old value
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= CTRL_INIT;
    end else if (ctrl_we) begin
      ctrl_ff <= ctrl_new;
    end
  end
endmodule

// >>> verif/vsu_unit_tb.sv
// Purpose: Self-checking bench for the vector subtract unit
// Assumes: One-cycle answer to every request
// Notes: The pipeline model keeps the control register
`timescale 1ns/100ps
module vsu_unit_tb
  import vsu_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic ext_enable = 1'b1;
  vsu_req_type req = '0;
  vsu_rsp_type rsp_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] ctrl_cur;
  logic [31:0] ctrl_before;
  logic ctrl_we_ff;
  logic trap_reserved_ff;
  logic trap_disabled_ff;
  int miscompares = 0;
  int n_tests = 0;
  localparam logic [5:0] MJ = VSU_MAJOR_OP;
  always #10 clock = ~clock;
  vsu_unit vsu_unit_i (.clock(clock), .rst_n(rst_n), .req(req), .ext_enable(ext_enable),
    .ctrl_in(ctrl_cur), .rsp_ff(rsp_ff), .ctrl_ff(ctrl_ff), .ctrl_we_ff(ctrl_we_ff),
    .trap_reserved_ff(trap_reserved_ff), .trap_disabled_ff(trap_disabled_ff));
  vsu_pipe_model vsu_pipe_model_i (.clock(clock), .rst_n(rst_n), .ctrl_we(ctrl_we_ff),
    .ctrl_new(ctrl_ff), .ctrl_ff(ctrl_cur));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Answer is read one edge after the request, while it stands
  task automatic run(input logic [5:0] mj, input logic [4:0] sub, input logic [5:0] fn,
                     input logic [31:0] a, input logic [31:0] b);
    @(posedge clock);
    req <= '{1'b1, {mj, 10'h000, 5'h03, sub, fn}, a, b};
    #1 ctrl_before = ctrl_cur;
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
  endtask
  task automatic chk_res(input logic [31:0] exp, input logic we);
    chk({26'h0, rsp_ff.valid, rsp_ff.dst}, 32'h0000_0023);
    chk(rsp_ff.data, exp);
    chk({31'h0, ctrl_we_ff}, {31'h0, we});
    if (we) begin
      chk(ctrl_ff, ctrl_before | 32'h0010_0000);
    end else begin
      chk(ctrl_ff, ctrl_before);
    end
  endtask
  task automatic chk_flags(input logic [3:0] exp);
    chk({28'h0, rsp_ff.valid, ctrl_we_ff, trap_reserved_ff, trap_disabled_ff}, {28'h0, exp});
  endtask
  task automatic t_halving();
    run(MJ, VSU_SUB_HWS, VSU_FN_HALVING, 32'h0000_0005, 32'h0000_0002);
    chk_res(32'h0000_0001, 1'b0);
    run(MJ, VSU_SUB_HWS_R, VSU_FN_HALVING, 32'h0000_0005, 32'h0000_0002);
    chk_res(32'h0000_0002, 1'b0);
    run(MJ, VSU_SUB_HWS, VSU_FN_HALVING, 32'h8000_0000, 32'h7FFF_FFFF);
    chk_res(32'h8000_0000, 1'b0);
    run(MJ, VSU_SUB_HWS_R, VSU_FN_HALVING, 32'h8000_0000, 32'h7FFF_FFFF);
    chk_res(32'h8000_0001, 1'b0);
    $display("halving test done");
  endtask
  task automatic t_pair();
    run(MJ, VSU_SUB_PAIR, VSU_FN_VECTOR, 32'h0003_0001, 32'h0001_0005);
    chk_res(32'hFFFE_0004, 1'b1);
    run(MJ, VSU_SUB_PAIR_S, VSU_FN_VECTOR, 32'h0003_0001, 32'h0001_0005);
    chk_res(32'h0000_0004, 1'b1);
    run(MJ, VSU_SUB_PAIR, VSU_FN_VECTOR, 32'h0001_0001, 32'h0002_0003);
    chk_res(32'h0001_0002, 1'b0);
    $display("pair test done");
  endtask
  task automatic t_quad();
    run(MJ, VSU_SUB_QUAD, VSU_FN_VECTOR, 32'h0102_0304, 32'h0202_0202);
    chk_res(32'hFF00_0102, 1'b1);
    run(MJ, VSU_SUB_QUAD_S, VSU_FN_VECTOR, 32'h0102_0304, 32'h0202_0202);
    chk_res(32'h0000_0102, 1'b1);
    run(MJ, VSU_SUB_QUAD, VSU_FN_VECTOR, 32'h0505_0505, 32'h0102_0304);
    chk_res(32'h0403_0201, 1'b0);
    $display("quad test done");
  endtask
  task automatic t_traps();
    run(MJ, 5'h1F, VSU_FN_VECTOR, 32'h0000_0001, 32'h0000_0002);
    chk_flags(4'h2);
    run(6'h00, VSU_SUB_QUAD, VSU_FN_VECTOR, 32'h0000_0001, 32'h0000_0002);
    chk_flags(4'h0);
    @(posedge clock);
    ext_enable <= 1'b0;
    run(MJ, VSU_SUB_QUAD, VSU_FN_VECTOR, 32'h0000_0001, 32'h0000_0002);
    chk_flags(4'h1);
    ext_enable <= 1'b1;
    $display("trap test done");
  endtask
  // Requests on consecutive edges, each answer read while it stands
  task automatic t_back();
    @(posedge clock);
    req <= '{1'b1, {MJ, 10'h000, 5'h03, VSU_SUB_QUAD_S, VSU_FN_VECTOR},
      32'h1010_1010, 32'h0F0F_0F0F};
    @(posedge clock);
    req <= '{1'b1, {MJ, 10'h000, 5'h03, VSU_SUB_PAIR, VSU_FN_VECTOR},
      32'h0001_0002, 32'h0004_0006};
    #1;
    chk_flags(4'h8);
    chk(rsp_ff.data, 32'h0101_0101);
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    chk_flags(4'h8);
    chk(rsp_ff.data, 32'h0003_0004);
    $display("back-to-back test done");
  endtask
  // Mid-run reset on the same edge a flag write is taken, then a request on the release edge
  task automatic t_reset();
    run(MJ, VSU_SUB_QUAD, VSU_FN_VECTOR, 32'h0000_0001, 32'h0000_0002);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    #1;
    chk_flags(4'h0);
    chk(ctrl_ff, VSU_CTRL_RESET);
    chk(rsp_ff.data, VSU_RESULT_RESET);
    @(posedge clock);
    rst_n <= 1'b1;
    req <= '{1'b1, {MJ, 10'h000, 5'h03, VSU_SUB_HWS, VSU_FN_HALVING},
      32'h0000_0009, 32'h0000_0001};
    #1 ctrl_before = ctrl_cur;
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    chk_res(32'h0000_0004, 1'b0);
    $display("reset test done");
  endtask
  task automatic results();
    $display("n_tests=%0d miscompares=%0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_halving();
    t_pair();
    t_quad();
    t_back();
    t_reset();
    t_traps();
    results();
  end
endmodule
